// ### cpsf_core.sv
`timescale 1ns/1ps
// Contract
// - after reset the program counter is zero, fetching from address 0
// - program counter advances by one or two words per instruction
// - jumps and calls load any program address, conditional or not
// - calls and interrupt entry push the return address automatically
// - return address is two bytes, three above 128KB; pointer moves alike
// - the return operation pops the return address into the program counter
// - byte push lowers stack pointer by one, pop raises it by one
// - reset loads stack pointer with highest internal SRAM address
// - stack pointer is two 8-bit bytes read and written in I/O space
// - low byte write holds off interrupts four instructions or next I/O write
// - status flags refresh after every ALU operation
// - interrupts neither save nor restore the status flags
// - 32 x 8-bit register file, 8/16-bit read and write schemes
// - six entries form three pointers, one also for program tables
module cpsf_core
(
	input  wire logic                     I_CLOCK,
	input  wire logic                     I_RST_N,
	input  wire logic                     I_INSTR_DONE,   // one instruction retires
	input  wire cpsf_pkg::cpsf_pcop_t     I_PC_OP,
	input  wire logic                     I_TWO_WORD,
	input  wire logic                     I_COND,         // jump/call condition
	input  wire logic [15:0]              I_TARGET,
	input  wire logic                     I_PUSH,
	input  wire logic                     I_POP,
	input  wire logic                     I_ALU_VALID,
	input  wire logic [7:0]               I_ALU_FLAGS,
	input  wire logic                     I_IO_WE,
	input  wire logic [11:0]              I_IO_ADDR,
	input  wire logic [7:0]               I_IO_WDATA,
	input  wire logic [15:0]              I_RET_DATA,     // return address read from stack
	input  wire logic                     I_IRQ_REQ,
	input  wire logic [4:0]               I_RA,
	input  wire logic [4:0]               I_RB,
	input  wire logic                     I_WE8,
	input  wire logic                     I_WE16,
	input  wire logic [4:0]               I_WA,
	input  wire logic [15:0]              I_WD,
	input  wire logic [1:0]               I_PSEL,
	output logic      [15:0]              O_PC,
	output logic      [15:0]              O_SP,
	output logic      [15:0]              O_RET_WDATA,    // return address to push
	output logic                          O_RET_WE,
	output logic      [7:0]               O_FLAGS,
	output logic      [7:0]               O_IO_RDATA,
	output logic                          O_IRQ_OK,
	output logic      [7:0]               O_DA,
	output logic      [7:0]               O_DB,
	output logic      [15:0]              O_DW,
	output logic      [15:0]              O_PTR,
	output logic      [15:0]              O_TPTR
);
	cpsf_rf_if rf ();
	cpsf_regfile i_cpsf_regfile (.i_clock(I_CLOCK), .i_rst_n(I_RST_N), .rf(rf));

	logic [15:0] pc, sp, next_pc, next_sp, pc_len, pc_ret;
	logic [7:0]  flags;
	logic [2:0]  guard, next_guard;
	logic        wr_stack_low, wr_stack_high, wr_sfr, is_call, is_ret, taken;

	assign rf.ra   = I_RA;
	assign rf.rb   = I_RB;
	assign rf.we8  = I_WE8;
	assign rf.we16 = I_WE16;
	assign rf.wa   = I_WA;
	assign rf.wd   = I_WD;
	assign rf.psel = I_PSEL;

	// decode
	assign wr_stack_low  = I_IO_WE && I_IO_ADDR == cpsf_pkg::IO_STACK_LOW;
	assign wr_stack_high = I_IO_WE && I_IO_ADDR == cpsf_pkg::IO_STACK_HIGH;
	assign wr_sfr  = I_IO_WE && I_IO_ADDR == cpsf_pkg::IO_SFR;
	assign pc_len  = I_TWO_WORD ? cpsf_pkg::STEP_TWO_WORDS : cpsf_pkg::STEP_ONE;
	assign pc_ret  = pc + pc_len;
	assign taken   = I_COND;
	assign is_call = (I_PC_OP == cpsf_pkg::CPSF_PC_CALL && taken) || I_PC_OP == cpsf_pkg::CPSF_PC_INT;
	assign is_ret  = I_PC_OP == cpsf_pkg::CPSF_PC_RET;

	// next program counter
	always_comb
	begin
		case (I_PC_OP)
			cpsf_pkg::CPSF_PC_HOLD: next_pc = pc;
			cpsf_pkg::CPSF_PC_NEXT: next_pc = pc_ret;
			cpsf_pkg::CPSF_PC_JUMP: next_pc = taken ? I_TARGET : pc_ret;
			cpsf_pkg::CPSF_PC_CALL: next_pc = taken ? I_TARGET : pc_ret;
			cpsf_pkg::CPSF_PC_INT:  next_pc = I_TARGET;
			cpsf_pkg::CPSF_PC_RET:  next_pc = I_RET_DATA;
			default:                next_pc = pc;
		endcase
	end

	// next stack pointer; software write wins over implicit moves
	always_comb
	begin
		next_sp = sp;
		if (is_call)
			next_sp = sp - cpsf_pkg::RET_STEP;
		else if (is_ret)
			next_sp = sp + cpsf_pkg::RET_STEP;
		else if (I_PUSH)
			next_sp = sp - cpsf_pkg::STEP_ONE;
		else if (I_POP)
			next_sp = sp + cpsf_pkg::STEP_ONE;
		if (wr_stack_low)
			next_sp = {next_sp[15:8], I_IO_WDATA};
		if (wr_stack_high)
			next_sp = {I_IO_WDATA, next_sp[7:0]};
	end

	// state registers
	always_ff @(posedge I_CLOCK)
	begin
		if (!I_RST_N)
		begin
			pc <= cpsf_pkg::PC_RESET;
			sp <= cpsf_pkg::SRAM_TOP;
		end
		else
		begin
			pc <= next_pc;
			sp <= next_sp;
		end
	end

	// flags: only ALU or software; interrupts leave them alone
	always_ff @(posedge I_CLOCK)
	begin
		if (!I_RST_N)
			flags <= 8'h00;
		else if (I_ALU_VALID)
			flags <= I_ALU_FLAGS;
		else if (wr_sfr)
			flags <= I_IO_WDATA;
	end

	// interrupt hold-off after low byte write; any other I/O write ends it
	assign next_guard = wr_stack_low ? cpsf_pkg::LOW_GUARD_INS :
	                    I_IO_WE ? 3'h0 :
	                    (I_INSTR_DONE && guard != 3'h0) ? guard - 3'h1 : guard;

	// hold-off counter, counts retired instructions down
	always_ff @(posedge I_CLOCK)
	begin
		if (!I_RST_N)
			guard <= 3'h0;
		else
			guard <= next_guard;
	end

	// registered outputs
	always_ff @(posedge I_CLOCK)
	begin
		if (!I_RST_N)
		begin
			O_PC        <= cpsf_pkg::PC_RESET;
			O_SP        <= cpsf_pkg::SRAM_TOP;
			O_RET_WDATA <= 16'h0000;
			O_RET_WE    <= 1'b0;
			O_FLAGS     <= 8'h00;
			O_IO_RDATA  <= 8'h00;
			O_IRQ_OK    <= 1'b0;
			O_DA        <= 8'h00;
			O_DB        <= 8'h00;
			O_DW        <= 16'h0000;
			O_PTR       <= 16'h0000;
			O_TPTR      <= 16'h0000;
		end
		else
		begin
			O_PC        <= next_pc;
			O_SP        <= next_sp;
			O_RET_WDATA <= (I_PC_OP == cpsf_pkg::CPSF_PC_INT) ? pc : pc_ret;
			O_RET_WE    <= is_call;
			O_FLAGS     <= flags;
			O_IO_RDATA  <= (I_IO_ADDR == cpsf_pkg::IO_STACK_LOW) ? sp[7:0] :
			               (I_IO_ADDR == cpsf_pkg::IO_STACK_HIGH) ? sp[15:8] :
			               (I_IO_ADDR == cpsf_pkg::IO_SFR) ? flags : 8'h00;
			O_IRQ_OK    <= I_IRQ_REQ && next_guard == 3'h0;                    // updated count, no extra cycle
			O_DA        <= rf.da;
			O_DB        <= rf.db;
			O_DW        <= rf.dw;
			O_PTR       <= rf.ptr;
			O_TPTR      <= rf.tptr;
		end
	end

	a_reset_pc: assert property (@(posedge I_CLOCK)
		!I_RST_N |=> pc == 16'h0000 && sp == cpsf_pkg::SRAM_TOP)
		else $error("reset values wrong");
	a_pc_advance: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		I_PC_OP == cpsf_pkg::CPSF_PC_NEXT |=> pc == $past(pc) + ($past(I_TWO_WORD) ? 16'h0002 : 16'h0001))
		else $error("pc advance wrong");
	a_jump_load: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		I_PC_OP == cpsf_pkg::CPSF_PC_JUMP && I_COND |=> pc == $past(I_TARGET))
		else $error("jump target not loaded");
	a_call_push: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		I_PC_OP == cpsf_pkg::CPSF_PC_CALL && I_COND |=> O_RET_WE && O_RET_WDATA == $past(pc_ret))
		else $error("call did not push return");
	a_call_sp: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		is_call && !I_IO_WE |=> sp == $past(sp) - 16'h0002)
		else $error("call stack step wrong");
	a_ret_pop: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		is_ret && !I_IO_WE |=> pc == $past(I_RET_DATA) && sp == $past(sp) + 16'h0002)
		else $error("return pop wrong");
	a_byte_push: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		I_PUSH && !is_call && !is_ret && !I_IO_WE |=> sp == $past(sp) - 16'h0001)
		else $error("push step wrong");
	a_low_write: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		wr_stack_low |=> sp[7:0] == $past(I_IO_WDATA))
		else $error("low byte write lost");
	a_irq_holdoff: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		wr_stack_low |=> !O_IRQ_OK)
		else $error("interrupt taken during hold-off");
	a_holdoff_io_end: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		I_IRQ_REQ && I_IO_WE && !wr_stack_low |=> O_IRQ_OK)
		else $error("hold-off outlived an I/O write");
	a_holdoff_count_end: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		I_IRQ_REQ && guard == 3'h1 && I_INSTR_DONE && !I_IO_WE |=> O_IRQ_OK)
		else $error("hold-off outlived four instructions");
	a_flags_int: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		I_PC_OP == cpsf_pkg::CPSF_PC_INT && !I_ALU_VALID && !wr_sfr |=> flags == $past(flags))
		else $error("flags touched by interrupt");
endmodule : cpsf_core

// ### cpsf_pkg.sv
package cpsf_pkg;
	localparam int          PC_W           = 16;     // word address bits, 128KB program memory
	localparam logic [15:0] PC_RESET       = 16'h0000;
	localparam int          SP_W           = 16;
	localparam logic [15:0] SRAM_TOP       = 16'h3FFF; // highest internal SRAM address
	localparam int          PROG_KB        = 128;
	localparam int          RET_BYTES      = (PROG_KB <= 128) ? 2 : 3;
	localparam logic [15:0] RET_STEP       = 16'(RET_BYTES);
	localparam logic [15:0] STEP_ONE       = 16'h0001;
	localparam logic [15:0] STEP_TWO_WORDS = 16'h0002;
	localparam logic [11:0] IO_STACK_LOW   = 12'h03D;  // stack pointer low byte
	localparam logic [11:0] IO_STACK_HIGH  = 12'h03E;  // stack pointer high byte
	localparam logic [11:0] IO_SFR         = 12'h03F;  // status flags register
	localparam logic [2:0]  LOW_GUARD_INS  = 3'h4;     // instructions held off after a low-byte write
	localparam int          RF_N           = 32;
	localparam logic [4:0]  PTR_LOW_BASE   = 5'h1A;    // first of six pointer registers
	localparam logic [4:0]  PTR_TABLE      = 5'h1E;    // pair also used for program-memory tables

	// program counter operations
	typedef enum logic [2:0] {
		CPSF_PC_HOLD,
		CPSF_PC_NEXT,
		CPSF_PC_JUMP,
		CPSF_PC_CALL,
		CPSF_PC_RET,
		CPSF_PC_INT
	} cpsf_pcop_t;
endpackage : cpsf_pkg

// ### cpsf_rf_if.sv
`timescale 1ns/1ps
interface cpsf_rf_if;
	logic [4:0]  ra;
	logic [4:0]  rb;
	logic [7:0]  da;
	logic [7:0]  db;
	logic [15:0] dw;      // 16-bit read of pair at ra
	logic        we8;
	logic        we16;
	logic [4:0]  wa;
	logic [15:0] wd;
	logic [1:0]  psel;
	logic [15:0] ptr;
	logic [15:0] tptr;
	modport core (output ra, rb, we8, we16, wa, wd, psel, input da, db, dw, ptr, tptr);
	modport file (input ra, rb, we8, we16, wa, wd, psel, output da, db, dw, ptr, tptr);
endinterface : cpsf_rf_if

// ### cpsf_regfile.sv
`timescale 1ns/1ps
module cpsf_regfile
(
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	cpsf_rf_if.file   rf
);
	logic [7:0] mem [cpsf_pkg::RF_N];
	logic [4:0] pa;
	logic [4:0] ra_even;

	// combinational reads, single cycle
	assign ra_even = {rf.ra[4:1], 1'b0};
	assign rf.da   = mem[rf.ra];
	assign rf.db   = mem[rf.rb];
	assign rf.dw   = {mem[ra_even + 5'h01], mem[ra_even]};
	assign pa      = cpsf_pkg::PTR_LOW_BASE + {2'h0, rf.psel, 1'b0};
	assign rf.ptr  = {mem[pa + 5'h01], mem[pa]};
	assign rf.tptr = {mem[cpsf_pkg::PTR_TABLE + 5'h01], mem[cpsf_pkg::PTR_TABLE]};

	// 8 or 16-bit write per entry
	genvar g;
	generate
		for (g = 0; g < cpsf_pkg::RF_N; g++)
		begin : g_ent
			always_ff @(posedge i_clock)
			begin
				if (!i_rst_n)
					mem[g] <= 8'h00;
				else if (rf.we16 && {rf.wa[4:1], 1'b0} == 5'(g))
					mem[g] <= rf.wd[7:0];
				else if (rf.we16 && {rf.wa[4:1], 1'b1} == 5'(g))
					mem[g] <= rf.wd[15:8];
				else if (rf.we8 && rf.wa == 5'(g))
					mem[g] <= rf.wd[7:0];
			end
		end
	endgenerate

	a_pair_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		rf.we16 && !rf.wa[0] |=> mem[$past(rf.wa)] == $past(rf.wd[7:0]))
		else $error("16-bit write low byte lost");
endmodule : cpsf_regfile

// ### cpsf_stack_model.sv
`timescale 1ns/1ps
// return-address stack in data sram, the far side of the core
module cpsf_stack_model
(
	input  wire logic        i_clock,
	input  wire logic        i_push,
	input  wire logic        i_pop,
	input  wire logic [15:0] i_wdata,
	output logic      [15:0] o_rdata
);
	logic [15:0] mem [0:15];
	logic [4:0]  depth = 5'h00;
	// store on push strobe, drop on return
	always_ff @(posedge i_clock)
	begin
		if (i_push)
		begin
			mem[depth[3:0]] <= i_wdata;
			depth           <= depth + 5'h01;
		end
		else if (i_pop && depth != 5'h00)
			depth <= depth - 5'h01;
	end
	// empty stack shows a junk pattern, never a held value
	assign o_rdata = (depth != 5'h00) ? mem[depth[3:0] - 4'h1] : 16'hDEAD;
endmodule : cpsf_stack_model

// ### cpu_stack_and_program_flow_bench.sv
`timescale 1ns/1ps
`define CHK(g,e) begin checked++; if ((g)!==(e)) begin num_errors++; \
	$display("BAD t=%0t got=%h exp=%h",$time,g,e); end end
module cpu_stack_and_program_flow_bench;
	logic                 I_CLOCK, I_RST_N, I_INSTR_DONE, I_TWO_WORD, I_COND, I_PUSH, I_POP;
	logic                 I_ALU_VALID, I_IO_WE, I_IRQ_REQ, I_WE8, I_WE16, O_RET_WE, O_IRQ_OK;
	cpsf_pkg::cpsf_pcop_t I_PC_OP;
	logic [15:0]          I_TARGET, I_RET_DATA, I_WD, O_PC, O_SP, O_RET_WDATA, O_DW, O_PTR, O_TPTR;
	logic [7:0]           I_ALU_FLAGS, I_IO_WDATA, O_FLAGS, O_IO_RDATA, O_DA, O_DB;
	logic [11:0]          I_IO_ADDR;
	logic [4:0]           I_RA, I_RB, I_WA;
	logic [1:0]           I_PSEL;
	int                   num_errors = 0, checked = 0;
	cpsf_core i_cpsf_core (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_INSTR_DONE(I_INSTR_DONE), .I_PC_OP(I_PC_OP),
		.I_TWO_WORD(I_TWO_WORD), .I_COND(I_COND), .I_TARGET(I_TARGET), .I_PUSH(I_PUSH), .I_POP(I_POP),
		.I_ALU_VALID(I_ALU_VALID), .I_ALU_FLAGS(I_ALU_FLAGS), .I_IO_WE(I_IO_WE), .I_IO_ADDR(I_IO_ADDR),
		.I_IO_WDATA(I_IO_WDATA), .I_RET_DATA(I_RET_DATA), .I_IRQ_REQ(I_IRQ_REQ), .I_RA(I_RA), .I_RB(I_RB),
		.I_WE8(I_WE8), .I_WE16(I_WE16), .I_WA(I_WA), .I_WD(I_WD), .I_PSEL(I_PSEL), .O_PC(O_PC), .O_SP(O_SP),
		.O_RET_WDATA(O_RET_WDATA), .O_RET_WE(O_RET_WE), .O_FLAGS(O_FLAGS), .O_IO_RDATA(O_IO_RDATA),
		.O_IRQ_OK(O_IRQ_OK), .O_DA(O_DA), .O_DB(O_DB), .O_DW(O_DW), .O_PTR(O_PTR), .O_TPTR(O_TPTR));
	cpsf_stack_model i_cpsf_stack_model (.i_clock(I_CLOCK), .i_push(O_RET_WE),
		.i_pop(I_PC_OP == cpsf_pkg::CPSF_PC_RET), .i_wdata(O_RET_WDATA), .o_rdata(I_RET_DATA));
	// core clock, 4 ns period
	initial
	begin
		I_CLOCK = 1'b0;
		forever #2 I_CLOCK = ~I_CLOCK;
	end
	// all strobes low, pc held
	task automatic idle;
		{I_INSTR_DONE, I_TWO_WORD, I_PUSH, I_POP, I_ALU_VALID, I_IO_WE, I_WE8, I_WE16} <= 8'h00;
		I_PC_OP <= cpsf_pkg::CPSF_PC_HOLD;
		I_COND  <= 1'b1;
	endtask : idle
	task automatic go;
		@(posedge I_CLOCK);
		idle();
		#1;
	endtask : go
	task automatic op(input cpsf_pkg::cpsf_pcop_t o, input logic w, input logic c, input logic [15:0] t);
		@(posedge I_CLOCK);
		I_PC_OP <= o;
		{I_TWO_WORD, I_COND, I_TARGET} <= {w, c, t};
		go();
	endtask : op
	task automatic iow(input logic [11:0] a, input logic [7:0] d);
		@(posedge I_CLOCK);
		{I_IO_WE, I_IO_ADDR, I_IO_WDATA} <= {1'b1, a, d};
		go();
	endtask : iow
	task automatic t_flow;
		op(cpsf_pkg::CPSF_PC_NEXT, 1'b0, 1'b1, 16'h0000); `CHK(O_PC, 16'h0001)
		op(cpsf_pkg::CPSF_PC_NEXT, 1'b1, 1'b1, 16'h0000); `CHK(O_PC, 16'h0003)
		op(cpsf_pkg::CPSF_PC_JUMP, 1'b1, 1'b1, 16'hFFFF); `CHK(O_PC, 16'hFFFF)
		op(cpsf_pkg::CPSF_PC_JUMP, 1'b0, 1'b1, 16'h0100); `CHK(O_PC, 16'h0100)
		op(cpsf_pkg::CPSF_PC_JUMP, 1'b0, 1'b0, 16'h1234); `CHK(O_PC, 16'h0101)
		op(cpsf_pkg::CPSF_PC_CALL, 1'b0, 1'b0, 16'h1234); `CHK(O_PC, 16'h0102)
		`CHK(O_SP, cpsf_pkg::SRAM_TOP)
	endtask : t_flow
	task automatic t_call;
		@(posedge I_CLOCK);
		{I_ALU_VALID, I_ALU_FLAGS} <= {1'b1, 8'h5A};
		op(cpsf_pkg::CPSF_PC_CALL, 1'b1, 1'b1, 16'h2000); `CHK(O_PC, 16'h2000)
		`CHK({O_RET_WE, O_RET_WDATA}, 17'h10104)
		`CHK(O_SP, cpsf_pkg::SRAM_TOP - 16'h0002)
		op(cpsf_pkg::CPSF_PC_INT, 1'b0, 1'b1, 16'h0004); `CHK({O_RET_WE, O_RET_WDATA}, 17'h12000)
		`CHK(O_SP, cpsf_pkg::SRAM_TOP - 16'h0004)
		op(cpsf_pkg::CPSF_PC_RET, 1'b0, 1'b1, 16'h0000); `CHK(O_PC, 16'h2000)
		`CHK(O_FLAGS, 8'h5A)
		op(cpsf_pkg::CPSF_PC_RET, 1'b0, 1'b1, 16'h0000); `CHK(O_PC, 16'h0104)
		`CHK(O_SP, cpsf_pkg::SRAM_TOP)
		@(posedge I_CLOCK);
		{I_ALU_VALID, I_ALU_FLAGS, I_IO_ADDR} <= {1'b1, 8'hC3, cpsf_pkg::IO_SFR};
		go(); go(); `CHK({O_FLAGS, O_IO_RDATA}, 16'hC3C3)
	endtask : t_call
	task automatic t_stack;
		@(posedge I_CLOCK);
		I_PUSH <= 1'b1;
		go(); `CHK(O_SP, cpsf_pkg::SRAM_TOP - 16'h0001)
		@(posedge I_CLOCK);
		{I_POP, I_IRQ_REQ} <= 2'b11;
		go(); `CHK(O_SP, cpsf_pkg::SRAM_TOP)
		// relocate above sram base, high byte first
		iow(cpsf_pkg::IO_STACK_HIGH, 8'h30);
		iow(cpsf_pkg::IO_STACK_LOW, 8'h00); `CHK({O_SP, O_IRQ_OK}, 17'h06000)
		for (int n = 0; n < 4; n++)
		begin
			`CHK(O_IRQ_OK, 1'b0)
			@(posedge I_CLOCK);
			I_INSTR_DONE <= 1'b1;
			go();
		end
		`CHK(O_IRQ_OK, 1'b1)
		iow(cpsf_pkg::IO_STACK_LOW, 8'h10); `CHK(O_IRQ_OK, 1'b0)
		iow(cpsf_pkg::IO_SFR, 8'h81); `CHK(O_IRQ_OK, 1'b1)
		@(posedge I_CLOCK);
		{I_IO_ADDR, I_IRQ_REQ} <= {cpsf_pkg::IO_STACK_HIGH, 1'b0};
		go(); go(); `CHK({O_SP, O_IO_RDATA}, 24'h301030)
	endtask : t_stack
	task automatic t_regs;
		@(posedge I_CLOCK);
		{I_WE8, I_WA, I_WD} <= {1'b1, 5'h05, 16'h00A5};
		@(posedge I_CLOCK);
		{I_WE8, I_WE16, I_WA, I_WD} <= {2'b01, 5'h1B, 16'h1234};
		@(posedge I_CLOCK);
		{I_WE16, I_WA, I_WD, I_RA, I_RB, I_PSEL} <= {1'b1, 5'h1E, 16'hBEEF, 5'h05, 5'h1A, 2'h0};
		go(); go(); `CHK({O_DA, O_DB, O_PTR, O_TPTR}, 48'hA5341234BEEF)
		@(posedge I_CLOCK);
		{I_RA, I_PSEL} <= {5'h1A, 2'h2};
		go(); go(); `CHK({O_DW, O_PTR}, 32'h1234BEEF)
	endtask : t_regs
	task automatic tally_and_finish;
		$display("mismatches %0d of %0d checks", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	// watchdog, runs are under a hundred cycles
	initial
	begin
		#20000;
		num_errors++;
		tally_and_finish();
	end
	initial
	begin
		idle();
		{I_RST_N, I_IRQ_REQ, I_TARGET, I_ALU_FLAGS, I_IO_WDATA, I_IO_ADDR} = '0;
		{I_RA, I_RB, I_WA, I_WD, I_PSEL} = '0;
		repeat (4) @(posedge I_CLOCK);
		I_RST_N <= 1'b1;
		#1;
		`CHK({O_PC, O_SP}, {cpsf_pkg::PC_RESET, cpsf_pkg::SRAM_TOP})
		t_flow();
		t_call();
		t_stack();
		t_regs();
		tally_and_finish();
	end
endmodule : cpu_stack_and_program_flow_bench
